/* File: rtc_consts.svh */
// register offsets, field positions, reset values and counts of the counter block
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// register offsets on the 3-bit register port
`define RTC_ADDR_W        3
`define RTC_OFS_CTRL      3'h0
`define RTC_OFS_PITCTRL   3'h1
`define RTC_OFS_INTCTRL   3'h2
`define RTC_OFS_STATUS    3'h3
`define RTC_OFS_COUNT     3'h4
`define RTC_OFS_PERIOD    3'h5
`define RTC_OFS_COMPARE   3'h6
`define RTC_OFS_CRYSTAL_ERROR_VALUE     3'h7

// control register fields
`define RTC_CTRL_RUN      0
`define RTC_CTRL_DIV_LO   1
`define RTC_CTRL_DIV_HI   4
`define RTC_CTRL_CORR     5
`define RTC_CTRL_SRC_LO   6
`define RTC_CTRL_SRC_HI   7

// periodic timer control fields
`define RTC_PIT_RUN       0
`define RTC_PIT_SEL_LO    1
`define RTC_PIT_SEL_HI    4

// interrupt enable fields
`define RTC_IE_OVF        0
`define RTC_IE_CMP        1
`define RTC_IE_PIT        2

// calibration fields
`define RTC_CAL_ERR_HI    6
`define RTC_CAL_SIGN      7

// reset values
`define RTC_PERIOD_RST    16'hFFFF
`define RTC_WORD_RST      16'h0000

// counts
`define RTC_CORR_INTERVAL 1000000
`define RTC_OSC_DIV_LAST  5'h1F
`define RTC_EVT_LO        5
`define RTC_EVT_HI        12

`endif

/* File: rtc_pkg.sv */
// types shared by the counter block files
package rtc_pkg;
    // counting clock sources
    typedef enum logic [1:0] {
        SRC_OSC,
        SRC_OSC_DIV32,
        SRC_XTAL,
        SRC_EXT
    } clk_src_e;

    typedef logic [15:0] word_t;
    typedef logic [6:0]  ppm_t;
endpackage

/* File: rtc_corr_if.sv */
// signals between the prescaler and its crystal correction unit
`timescale 1ns/1ps
interface rtc_corr_if;
    logic               tick;       // crystal-source counting clock tick reaching the prescaler
    logic               enable;     // correction wanted by software
    logic               negative;   // crystal fast: skip counts
    rtc_pkg::ppm_t      err;        // ppm value
    logic               speed_up;   // advance prescaler by two this tick
    logic               slow_down;  // hold prescaler this tick
    logic               active;     // an interval is in progress

    modport core (output tick, output enable, output negative, output err,
                  input speed_up, input slow_down, input active);
    modport corr (input tick, input enable, input negative, input err,
                  output speed_up, output slow_down, output active);
endinterface

/* File: rtc_corr.sv */
// crystal correction: spreads err corrections over each interval of ticks
`timescale 1ns/1ps
`include "rtc_consts.svh"
module rtc_corr #(
    parameter int INTERVAL = `RTC_CORR_INTERVAL
) (
    input  wire logic   clk_i,
    input  wire logic   arst_n_i,
    rtc_corr_if.corr    cif
);
    logic [19:0] acc;        // error accumulator
    logic [19:0] ticks;      // position inside the interval
    logic        active;     // interval running
    logic        fire;       // correction due on this tick

    wire [19:0] next_acc_sum = acc + {13'h0000, cif.err};
    wire        interval_end = (ticks == 20'(INTERVAL - 1));

    // a correction fires whenever the accumulator passes one interval
    assign fire          = active && cif.tick && (next_acc_sum >= 20'(INTERVAL));
    assign cif.speed_up  = fire && !cif.negative;
    assign cif.slow_down = fire && cif.negative;
    assign cif.active    = active;

    ////////////////////////////////////////////////////////////////////////////
    // interval bookkeeping
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc    <= 20'h00000;
            ticks  <= 20'h00000;
            active <= 1'b0;
        end else if (cif.tick) begin
            if (!active || interval_end) begin
                active <= cif.enable;
                ticks  <= 20'h00000;
                acc    <= 20'h00000;
            end else begin
                ticks <= ticks + 20'h00001;
                acc   <= fire ? next_acc_sum - 20'(INTERVAL) : next_acc_sum;
            end
        end
    end

    // interval_guard_a: no correction outside a running interval
    interval_guard_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cif.speed_up || cif.slow_down) |-> (active && cif.tick))
        else $error("correction outside an interval");
    // finish_interval_a: an interval runs on after enable drops
    finish_interval_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (active && cif.tick && !interval_end) |=> active)
        else $error("correction interval cut short");
endmodule

/* File: rtc_core.sv */
// real-time counter with shared prescaler, periodic timer and crystal correction
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "rtc_consts.svh"

// Notes on behaviour
// - fifteen-bit prescaler divides the counting clock
// - compare pulse on count after match
// - overflow pulse on count after period
// - overflow returns the counter to zero
// - periodic timer runs without the counter
// - four counting clock sources selectable
// - correction one ppm steps, up to 127
// - sign picks skipping or inserting counts
// - correction only with crystal source
// - periodic interrupt every two-power period
// - level events from 64 to 8192
// - periodic timer shares the prescaler clock
// - keeps counting, wakes at regular intervals
// - prescaler stopped while both enables clear
// - timer output toggles every half period
// - corrections spread over million-tick interval
// - running interval finishes after disable
module rtc_core #(
    parameter int CORR_INTERVAL = `RTC_CORR_INTERVAL
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        xtal_tick_i,
    input  wire logic        ext_tick_i,
    input  wire logic        osc_tick_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic             ovf_evt_o,
    output logic             cmp_evt_o,
    output logic             ovf_irq_o,
    output logic             cmp_irq_o,
    output logic             pit_irq_o,
    output logic             pit_wave_o,
    output logic      [7:0]  pit_evt_o
);
    ////////////////////////////////////////////////////////////////////////////
    // software registers
    logic [7:0]           ctrl;        // run, divider, correction, source
    logic [4:0]           pit_ctrl;    // timer run and period select
    logic [2:0]           int_ctrl;    // interrupt request enables
    rtc_pkg::word_t       period;      // overflow value
    rtc_pkg::word_t       compare;     // compare value
    logic [7:0]           crystal_error_value;       // sign and ppm error

    // block state
    logic [14:0]          presc;       // shared prescaler counter
    rtc_pkg::word_t       count;       // the counter itself
    logic [4:0]           osc_div;     // divide-by-32 for the oscillator

    rtc_corr_if cif ();

    ////////////////////////////////////////////////////////////////////////////
    // register field decode
    wire                  rtc_run  = ctrl[`RTC_CTRL_RUN];
    wire [3:0]            div_sel  = ctrl[`RTC_CTRL_DIV_HI:`RTC_CTRL_DIV_LO];
    wire                  corr_en  = ctrl[`RTC_CTRL_CORR];
    wire rtc_pkg::clk_src_e src    = rtc_pkg::clk_src_e'(ctrl[`RTC_CTRL_SRC_HI:`RTC_CTRL_SRC_LO]);
    wire                  pit_run  = pit_ctrl[`RTC_PIT_RUN];
    wire [3:0]            pit_sel  = pit_ctrl[`RTC_PIT_SEL_HI:`RTC_PIT_SEL_LO];

    wire wr_ctrl    = wr_i && (addr_i == `RTC_OFS_CTRL);
    wire wr_pitctrl = wr_i && (addr_i == `RTC_OFS_PITCTRL);
    wire wr_intctrl = wr_i && (addr_i == `RTC_OFS_INTCTRL);
    wire wr_period  = wr_i && (addr_i == `RTC_OFS_PERIOD);
    wire wr_compare = wr_i && (addr_i == `RTC_OFS_COMPARE);
    wire wr_crystal_error_value   = wr_i && (addr_i == `RTC_OFS_CRYSTAL_ERROR_VALUE);

    ////////////////////////////////////////////////////////////////////////////
    // counting clock selection
    // oscillator divided by 32 gives one tick per 32 oscillator ticks
    wire osc32_tick = osc_tick_i && (osc_div == `RTC_OSC_DIV_LAST);

    wire src_tick = (src == rtc_pkg::SRC_OSC)       ? osc_tick_i  :
                    (src == rtc_pkg::SRC_OSC_DIV32) ? osc32_tick  :
                    (src == rtc_pkg::SRC_XTAL)      ? xtal_tick_i : ext_tick_i;

    // prescaler runs if either function is on
    // timer alone keeps the prescaler going
    wire presc_run = rtc_run || pit_run;
    wire cnt_tick  = src_tick && presc_run;

    // correction only offered for the crystal
    assign cif.tick     = cnt_tick && (src == rtc_pkg::SRC_XTAL);
    // ppm value and sign handed to correction
    assign cif.enable   = corr_en;
    assign cif.negative = crystal_error_value[`RTC_CAL_SIGN];
    assign cif.err      = crystal_error_value[`RTC_CAL_ERR_HI:0];

    // skip a count or insert one
    wire [1:0]  step   = !cnt_tick      ? 2'h0 :
                         cif.speed_up   ? 2'h2 :
                         cif.slow_down  ? 2'h0 : 2'h1;
    wire [15:0] next_presc_sum = {1'b0, presc} + {14'h0000, step};

    // divide by two to the power div_sel
    // a +2 step at divide-by-one still gives a single tick, so at that
    // setting the speed-up adds no count to the counter
    wire [15:0] div_mask   = 16'hFFFF << div_sel;
    // prescaled tick when the masked bits change
    wire        presc_tick = |((next_presc_sum ^ {1'b0, presc}) & div_mask);
    // counter only moves on a prescaled tick
    wire        cnt_step   = presc_tick && rtc_run;

    wire        at_period  = (count == period);
    wire        at_compare = (count == compare);

    // timer level taken from the shared prescaler bits
    // select 15 reads the zero pad, so that setting leaves the timer off
    wire [15:0] presc_ext  = {1'b0, next_presc_sum[14:0]};
    wire        next_wave  = pit_run && (pit_sel != 4'h0) && presc_ext[pit_sel];

    ////////////////////////////////////////////////////////////////////////////
    // register writes; a write to the counter word is ignored
    // limitation: a period written below the running count is only met
    // after the counter rolls over at the top of its range
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl     <= 8'h00;
            pit_ctrl <= 5'h00;
            int_ctrl <= 3'h0;
            period   <= `RTC_PERIOD_RST;
            compare  <= `RTC_WORD_RST;
            crystal_error_value    <= 8'h00;
        end else begin
            if (wr_ctrl)    ctrl     <= wdata_i[7:0];
            if (wr_pitctrl) pit_ctrl <= wdata_i[4:0];
            if (wr_intctrl) int_ctrl <= wdata_i[2:0];
            if (wr_period)  period   <= wdata_i;
            if (wr_compare) compare  <= wdata_i;
            if (wr_crystal_error_value)   crystal_error_value    <= wdata_i[7:0];
        end
    end

    // oscillator divider, free running on its own ticks
    // it runs while deselected, so the first slow tick after a switch may come early
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_div <= 5'h00;
        end else if (osc_tick_i) begin
            osc_div <= osc_div + 5'h01;
        end
    end

    // prescaler; holds its value while stopped
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            presc <= 15'h0000;
        end else begin
            presc <= next_presc_sum[14:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter with period wrap
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= `RTC_WORD_RST;
        end else if (cnt_step) begin
            count <= at_period ? 16'h0000 : count + 16'h0001;
        end
    end

    // event and request pulses, one cycle each
    // events ignore the request enables, so masked requests still leave events
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovf_evt_o <= 1'b0;
            cmp_evt_o <= 1'b0;
            ovf_irq_o <= 1'b0;
            cmp_irq_o <= 1'b0;
        end else begin
            // overflow pulse on the count past period
            ovf_evt_o <= cnt_step && at_period;
            // compare pulse on the count past compare
            cmp_evt_o <= cnt_step && at_compare;
            // requests that can wake the processor
            ovf_irq_o <= cnt_step && at_period && int_ctrl[`RTC_IE_OVF];
            cmp_irq_o <= cnt_step && at_compare && int_ctrl[`RTC_IE_CMP];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // periodic timer: square wave, request on each rising edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pit_wave_o <= 1'b0;
            pit_irq_o  <= 1'b0;
        end else begin
            pit_wave_o <= next_wave;
            pit_irq_o  <= next_wave && !pit_wave_o && int_ctrl[`RTC_IE_PIT];
        end
    end

    // level events, one per prescaler bit 5 to 12
    genvar gi;
    generate
        for (gi = `RTC_EVT_LO; gi <= `RTC_EVT_HI; gi++) begin : g_evt
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    pit_evt_o[gi - `RTC_EVT_LO] <= 1'b0;
                end else begin
                    pit_evt_o[gi - `RTC_EVT_LO] <= pit_run && next_presc_sum[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read multiplexer; every offset is mapped
    rtc_pkg::word_t read_word;
    // whole counter captured in one cycle
    // a single capture of the full word, so no half-old value is read
    assign read_word =
        (addr_i == `RTC_OFS_CTRL)    ? {8'h00, ctrl}            :
        (addr_i == `RTC_OFS_PITCTRL) ? {11'h000, pit_ctrl}      :
        (addr_i == `RTC_OFS_INTCTRL) ? {13'h0000, int_ctrl}     :
        (addr_i == `RTC_OFS_STATUS)  ? {14'h0000, cif.active, pit_wave_o} :
        (addr_i == `RTC_OFS_COUNT)   ? count                    :
        (addr_i == `RTC_OFS_PERIOD)  ? period                   :
        (addr_i == `RTC_OFS_COMPARE) ? compare                  : {8'h00, crystal_error_value};

    // read data held until the next read
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            rdata_o <= read_word;
        end
    end

    // correction unit
    // interval length is a parameter so a bench can keep runs short
    rtc_corr #(
        .INTERVAL (CORR_INTERVAL)
    ) u_corr (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .cif      (cif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    counter_step_a: assert property (cnt_step && !at_period |=>
        count == $past(count) + 16'h0001)
        else $error("counter did not advance by one");
    presc_divide_a: assert property (!presc_tick |=> $stable(count))
        else $error("counter moved without prescaled tick");
    compare_pulse_a: assert property (cnt_step && at_compare |=> cmp_evt_o)
        else $error("compare pulse missing");
    overflow_pulse_a: assert property (cnt_step && at_period |=> ovf_evt_o)
        else $error("overflow pulse missing");
    wrap_zero_a: assert property (cnt_step && at_period |=> count == 16'h0000)
        else $error("counter did not wrap to zero");
    pit_alone_a: assert property (pit_run && !rtc_run && src_tick && !cif.slow_down
        |=> presc != $past(presc))
        else $error("prescaler idle with timer enabled");
    source_pick_a: assert property (src == rtc_pkg::SRC_XTAL && rtc_run
        && !xtal_tick_i |=> $stable(presc))
        else $error("prescaler moved without crystal tick");
    corr_xtal_a: assert property (src != rtc_pkg::SRC_XTAL
        |-> !cif.speed_up && !cif.slow_down)
        else $error("correction applied off crystal");
    skip_count_a: assert property (cif.speed_up
        |=> presc == $past(presc) + 15'h0002)
        else $error("skip did not advance by two");
    presc_stop_a: assert property (!rtc_run && !pit_run |=> $stable(presc))
        else $error("prescaler ran with both enables clear");
    pit_request_a: assert property (pit_irq_o |-> pit_wave_o && !$past(pit_wave_o))
        else $error("timer request without rising level");
    evt_level_a: assert property (pit_run |=> pit_evt_o == $past(next_presc_sum[12:5]))
        else $error("event levels wrong");

    // requests never stand without their event, and idle parts stay quiet
    ovf_req_a: assert property (ovf_irq_o |-> ovf_evt_o)
        else $error("overflow request without event");
    cmp_req_a: assert property (cmp_irq_o |-> cmp_evt_o)
        else $error("compare request without event");
    timer_off_a: assert property (!pit_run |=> !pit_wave_o && pit_evt_o == 8'h00)
        else $error("timer outputs active while off");
    count_hold_a: assert property (!rtc_run |=> $stable(count))
        else $error("counter moved while disabled");
    slow_source_a: assert property (src == rtc_pkg::SRC_OSC_DIV32
        && osc_div != `RTC_OSC_DIV_LAST |-> !cnt_tick)
        else $error("divided source ticked early");
endmodule

/* File: tb_rtc_core.sv */
// self-checking bench for the real-time counter block
`timescale 1ns/1ps
`include "rtc_consts.svh"
module tb;
    // one write/readback row: address, data written, value read back
    typedef struct {
        logic [2:0]     a;
        rtc_pkg::word_t w;
        rtc_pkg::word_t e;
    } row_s;

    logic           clk_i    = 1'b0;
    logic           arst_n_i = 1'b0;
    logic [2:0]     tk       = 3'h0;      // {ext, xtal, osc} tick lines
    logic [2:0]     addr_i   = 3'h0;
    rtc_pkg::word_t wdata_i  = 16'h0000;
    logic           wr_i     = 1'b0;
    logic           rd_i     = 1'b0;
    rtc_pkg::word_t rdata_o;
    logic           ovf_evt_o, cmp_evt_o, ovf_irq_o, cmp_irq_o, pit_irq_o, pit_wave_o;
    logic [7:0]     pit_evt_o;
    int             n_mismatch, compares;
    int             n_ovf, n_cmp, n_oirq, n_cirq, n_pirq;  // pulse tallies
    rtc_pkg::word_t v;
    row_s           rows [8];
    int             divs [3] = '{0, 2, 3};  // prescaler exponents tried

    // short interval keeps the correction runs brief
    rtc_core #(.CORR_INTERVAL(100)) u_dut (
        .clk_i      (clk_i),
        .arst_n_i   (arst_n_i),
        .xtal_tick_i(tk[1]),
        .ext_tick_i (tk[2]),
        .osc_tick_i (tk[0]),
        .addr_i     (addr_i),
        .wdata_i    (wdata_i),
        .wr_i       (wr_i),
        .rd_i       (rd_i),
        .rdata_o    (rdata_o),
        .ovf_evt_o  (ovf_evt_o),
        .cmp_evt_o  (cmp_evt_o),
        .ovf_irq_o  (ovf_irq_o),
        .cmp_irq_o  (cmp_irq_o),
        .pit_irq_o  (pit_irq_o),
        .pit_wave_o (pit_wave_o),
        .pit_evt_o  (pit_evt_o)
    );

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    // tally one-cycle pulses so none is missed between checks
    always @(posedge clk_i) begin
        if (ovf_evt_o === 1'b1) n_ovf++;
        if (cmp_evt_o === 1'b1) n_cmp++;
        if (ovf_irq_o === 1'b1) n_oirq++;
        if (cmp_irq_o === 1'b1) n_cirq++;
        if (pit_irq_o === 1'b1) n_pirq++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input rtc_pkg::word_t seen, input rtc_pkg::word_t exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // reset held three cycles; tallies cleared with it
    task automatic do_reset;
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        n_ovf = 0; n_cmp = 0; n_oirq = 0; n_cirq = 0; n_pirq = 0;
    endtask

    task automatic wr(input logic [2:0] a, input rtc_pkg::word_t d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stands in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output rtc_pkg::word_t d);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic tick(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge clk_i);
            tk <= m;
            @(posedge clk_i);
            tk <= 3'h0;
            repeat (2) @(posedge clk_i);
        end
    endtask

    // hang guard, far beyond the few thousand cycles the run needs
    initial begin
        #200us;
        n_mismatch++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        // ordinary cases: write then read back, narrow fields and read-only places
        rows[0] = '{`RTC_OFS_CTRL,    16'hFFFE, 16'h00FE};
        rows[1] = '{`RTC_OFS_PITCTRL, 16'hFFFE, 16'h001E};
        rows[2] = '{`RTC_OFS_INTCTRL, 16'hFFFF, 16'h0007};
        rows[3] = '{`RTC_OFS_STATUS,  16'hFFFF, 16'h0000};
        rows[4] = '{`RTC_OFS_COUNT,   16'h5555, 16'h0000};
        rows[5] = '{`RTC_OFS_PERIOD,  16'h1234, 16'h1234};
        rows[6] = '{`RTC_OFS_COMPARE, 16'hABCD, 16'hABCD};
        rows[7] = '{`RTC_OFS_CRYSTAL_ERROR_VALUE,   16'hFFFF, 16'h00FF};
        do_reset();
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            check("reset value", v, (i == 5) ? `RTC_PERIOD_RST : `RTC_WORD_RST);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, v);
            check("readback", v, rows[i].e);
        end

        // every source drives the counter, the others are ignored
        for (int s = 0; s < 4; s++) begin
            do_reset();
            wr(`RTC_OFS_CTRL, 16'((s << 6) | 1));
            tick((s == 2) ? 3'h5 : (s == 3) ? 3'h3 : 3'h6, 2);
            tick((s == 2) ? 3'h2 : (s == 3) ? 3'h4 : 3'h1, (s == 1) ? 64 : 2);
            rd(`RTC_OFS_COUNT, v);
            check("count per source", v, 16'h0002);
        end

        // prescaler ratios 1, 4 and 8
        foreach (divs[k]) begin
            do_reset();
            wr(`RTC_OFS_CTRL, 16'((divs[k] << 1) | 1));
            tick(3'h1, 3 << divs[k]);
            rd(`RTC_OFS_COUNT, v);
            check("prescaled count", v, 16'h0003);
        end

        // period 2, compare 1: count cycles 0,1,2 and pulses once per lap
        do_reset();
        wr(`RTC_OFS_PERIOD, 16'h0002);
        wr(`RTC_OFS_COMPARE, 16'h0001);
        wr(`RTC_OFS_INTCTRL, 16'h0003);
        wr(`RTC_OFS_CTRL, 16'h0001);
        tick(3'h1, 10);
        rd(`RTC_OFS_COUNT, v);
        check("count after laps", v, 16'h0001);
        check("overflow events", 16'(n_ovf), 16'h0003);
        check("compare events", 16'(n_cmp), 16'h0003);
        check("overflow requests", 16'(n_oirq), 16'h0003);
        check("compare requests", 16'(n_cirq), 16'h0003);
        check("level events off", {8'h00, pit_evt_o}, 16'h0000);
        // requests masked, events still come
        wr(`RTC_OFS_INTCTRL, 16'h0000);
        n_ovf = 0; n_cmp = 0; n_oirq = 0; n_cirq = 0;
        tick(3'h1, 3);
        check("masked requests", 16'(n_oirq + n_cirq), 16'h0000);
        check("events unmasked", 16'(n_ovf + n_cmp), 16'h0002);
        // counter frozen when disabled
        wr(`RTC_OFS_CTRL, 16'h0000);
        tick(3'h1, 2);
        rd(`RTC_OFS_COUNT, v);
        check("frozen count", v, 16'h0001);

        // periodic timer alone; idle ticks first must not move the prescaler
        for (int s = 1; s < 5; s++) begin
            do_reset();
            wr(`RTC_OFS_INTCTRL, 16'h0004);
            tick(3'h1, 2);
            wr(`RTC_OFS_PITCTRL, 16'((s << 1) | 1));
            for (int k = 1; k <= (4 << s); k++) begin
                tick(3'h1, 1);
                check("timer wave", {15'h0, pit_wave_o}, {15'h0, k[s]});
                check("level events", {8'h00, pit_evt_o}, {8'h00, k[12:5]});
            end
            check("timer requests", 16'(n_pirq), 16'h0002);
        end

        // speed up by 28 per interval; correction cleared mid-interval
        do_reset();
        wr(`RTC_OFS_CRYSTAL_ERROR_VALUE, 16'h001C);
        wr(`RTC_OFS_PITCTRL, 16'h0003);
        wr(`RTC_OFS_CTRL, 16'h00A0);
        tick(3'h2, 50);
        rd(`RTC_OFS_STATUS, v);
        check("interval active", {15'h0, v[1]}, 16'h0001);
        wr(`RTC_OFS_CTRL, 16'h0080);
        // the enabling tick only opens the interval, which closes on tick 101
        tick(3'h2, 51);
        check("faster prescaler", {8'h00, pit_evt_o}, 16'h0004);
        rd(`RTC_OFS_STATUS, v);
        check("interval over", {15'h0, v[1]}, 16'h0000);
        tick(3'h2, 100);
        check("plain prescaler", {8'h00, pit_evt_o}, 16'h0007);
        // slow down by 28
        do_reset();
        wr(`RTC_OFS_CRYSTAL_ERROR_VALUE, 16'h009C);
        wr(`RTC_OFS_PITCTRL, 16'h0003);
        wr(`RTC_OFS_CTRL, 16'h00A0);
        tick(3'h2, 100);
        check("slower prescaler", {8'h00, pit_evt_o}, 16'h0002);
        // no correction off the crystal
        do_reset();
        wr(`RTC_OFS_CRYSTAL_ERROR_VALUE, 16'h001C);
        wr(`RTC_OFS_PITCTRL, 16'h0003);
        wr(`RTC_OFS_CTRL, 16'h0020);
        tick(3'h1, 100);
        check("uncorrected", {8'h00, pit_evt_o}, 16'h0003);
        end_of_test();
    end
endmodule
